/* design/pdr_pkg.sv */
/*
 * Constants, state type and line layout for the parallel download receiver.
 * Assumes a 10 MHz system clock and a compatibility-mode host on the port.
 */
// Contract
// R1: Host sets data, checks busy, then strobes.
// R2: On strobe, latch byte, then pulse acknowledge.
// R3: Host releases strobe during acknowledge.
// R4: Handshake repeats once per byte until done.
// R5: Select-in and init mark mode and start.
// R6: Eight data, five status, four control lines.
// R7: Compatibility-mode peripheral only, no extended mode.
// R8: Sustain 200 Kbytes/second without losing bytes.
// R9: Busy from strobe until byte handed on.
// R10: Synchronise controls, act once per strobe edge.
package pdr_pkg;

    // ----------------------------------------
    // Line widths
    // ----------------------------------------
    localparam int DATA_W       = 8;
    localparam int CTRL_LINES   = 4;
    localparam int STATUS_LINES = 5;
    localparam int COUNT_W      = 32;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int ACK_PULSE_NS   = 1000;
    localparam int ACK_CYCLES     = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_PERIOD_NS = 5000;
    localparam int BYTE_CYCLES    = BYTE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ACK_CNT_W      = 8;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic ACK_N_RESET     = 1'b1;
    localparam logic BUSY_RESET      = 1'b1;
    localparam logic FAULT_N_RESET   = 1'b1;
    localparam logic PAPER_OUT_RESET = 1'b0;
    localparam logic SELECT_RESET    = 1'b0;
    localparam logic LINE_IDLE       = 1'b1;

    // ----------------------------------------
    // Receiver states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_HANDOFF,
        ST_ACK,
        ST_RELEASE
    } rx_state_e;

endpackage

/* design/line_if.sv */
/*
 * Conditioned host lines passed from the line conditioner to the receiver.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface line_if;
    logic [pdr_pkg::DATA_W-1:0] data;
    logic                       strobe_n;
    logic                       autofd_n;
    logic                       init_n;
    logic                       select_in_n;

    modport source
    (
        output data,
        output strobe_n,
        output autofd_n,
        output init_n,
        output select_in_n
    );

    modport sink
    (
        input data,
        input strobe_n,
        input autofd_n,
        input init_n,
        input select_in_n
    );
endinterface

/* design/line_conditioner.sv */
/*
 * Three-stage synchroniser and agreement filter for every host line.
 * Assumes the host lines are asynchronous to clk_i.
 */
`timescale 1ns/1ns
module line_conditioner
    import pdr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // Host pins
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              strobe_n_i,
    input  wire logic              autofd_n_i,
    input  wire logic              init_n_i,
    input  wire logic              select_in_n_i,
    // Conditioned lines
    line_if.source                 lines
);

    localparam int N = DATA_W + CTRL_LINES;

    logic [N-1:0] raw;
    logic [N-1:0] stage1;
    logic [N-1:0] stage2;
    logic [N-1:0] stage3;
    logic [N-1:0] filtered;

    assign raw = {data_i, strobe_n_i, autofd_n_i, init_n_i, select_in_n_i};

    // ----------------------------------------
    // Synchroniser chain
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage1 <= {N{LINE_IDLE}};
            stage2 <= {N{LINE_IDLE}};
            stage3 <= {N{LINE_IDLE}};
        end
        else
        begin
            stage1 <= raw;    // [R10]
            stage2 <= stage1; // [R10]
            stage3 <= stage2; // [R10]
        end
    end

    // ----------------------------------------
    // Agreement filter
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            filtered <= {N{LINE_IDLE}};
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (stage2[i] == stage3[i])
                begin
                    filtered[i] <= stage3[i]; // [R10]
                end
            end
        end
    end

    assign lines.data        = filtered[N-1:CTRL_LINES];
    assign lines.strobe_n    = filtered[3];
    assign lines.autofd_n    = filtered[2];
    assign lines.init_n      = filtered[1];
    assign lines.select_in_n = filtered[0];

endmodule // line_conditioner

/* design/parallel_download_receiver.sv */
/*
 * Compatibility-mode parallel port peripheral receiving download bytes.
 * Assumes a host that follows the busy/strobe/acknowledge handshake and
 * a downstream sink with a valid/ready handoff on clk_i.
 */
`timescale 1ns/1ns
module parallel_download_receiver
(
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    // Host data and control lines
    input  wire logic [pdr_pkg::DATA_W-1:0] data_i,
    input  wire logic                       strobe_n_i,
    input  wire logic                       autofd_n_i,
    input  wire logic                       init_n_i,
    input  wire logic                       select_in_n_i,
    // Status lines to host
    output logic                            ack_n_o,
    output logic                            busy_o,
    output logic                            paper_out_o,
    output logic                            select_o,
    output logic                            fault_n_o,
    // Downstream byte stream
    output logic [pdr_pkg::DATA_W-1:0]      byte_o,
    output logic                            byte_valid_o,
    input  wire logic                       byte_ready_i,
    // Download framing
    output logic                            download_mode_o,
    output logic                            download_start_o,
    output logic [pdr_pkg::COUNT_W-1:0]     byte_count_o
);

    import pdr_pkg::*;

    line_if lines ();

    rx_state_e            state;
    rx_state_e            next_state;
    logic                 strobe_prev;
    logic                 init_prev;
    logic                 strobe_fall;
    logic                 init_rise;
    logic                 mode;
    logic [ACK_CNT_W-1:0] ack_cnt;

    // ----------------------------------------
    // Line conditioning
    // ----------------------------------------
    line_conditioner u_cond
    (
        .clk_i         (clk_i),
        .reset_n_i     (reset_n_i),
        .data_i        (data_i),
        .strobe_n_i    (strobe_n_i),
        .autofd_n_i    (autofd_n_i),
        .init_n_i      (init_n_i),
        .select_in_n_i (select_in_n_i),
        .lines         (lines)
    );

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            strobe_prev <= LINE_IDLE;
            init_prev   <= LINE_IDLE;
        end
        else
        begin
            strobe_prev <= lines.strobe_n;
            init_prev   <= lines.init_n;
        end
    end

    assign strobe_fall = strobe_prev && !lines.strobe_n;  // [R10]
    assign init_rise   = !init_prev && lines.init_n;      // [R5]
    assign mode        = !lines.select_in_n && lines.init_n; // [R5]

    // ----------------------------------------
    // Handshake state machine
    // ----------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (mode && strobe_fall)
                begin
                    next_state = ST_HANDOFF; // [R2]
                end
            end
            ST_HANDOFF:
            begin
                if (!mode)
                begin
                    next_state = ST_IDLE;
                end
                else if (byte_ready_i)
                begin
                    next_state = ST_ACK; // [R9]
                end
            end
            ST_ACK:
            begin
                if (!mode)
                begin
                    next_state = ST_IDLE;
                end
                else if (ack_cnt == ACK_CNT_W'(ACK_CYCLES - 1))
                begin
                    next_state = ST_RELEASE; // [R2]
                end
            end
            ST_RELEASE:
            begin
                if (!mode || lines.strobe_n)
                begin
                    next_state = ST_IDLE; // [R3] [R4]
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Acknowledge pulse timer
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_cnt <= '0;
        end
        else if (state == ST_ACK)
        begin
            ack_cnt <= ack_cnt + ACK_CNT_W'(1);
        end
        else
        begin
            ack_cnt <= '0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_n_o <= ACK_N_RESET;
        end
        else
        begin
            ack_n_o <= !(next_state == ST_ACK); // [R2]
        end
    end

    // ----------------------------------------
    // Busy line
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            busy_o <= BUSY_RESET;
        end
        else
        begin
            busy_o <= !mode || (next_state != ST_IDLE); // [R9] [R1]
        end
    end

    // ----------------------------------------
    // Byte capture and handoff
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            byte_o <= '0;
        end
        else if (state == ST_IDLE && mode && strobe_fall)
        begin
            byte_o <= lines.data; // [R2] [R6]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            byte_valid_o <= 1'b0;
        end
        else
        begin
            byte_valid_o <= (next_state == ST_HANDOFF) && mode; // [R8] [R9]
        end
    end

    // ----------------------------------------
    // Download framing and count
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            download_mode_o  <= 1'b0;
            download_start_o <= 1'b0;
        end
        else
        begin
            download_mode_o  <= mode;                              // [R5]
            download_start_o <= init_rise && !lines.select_in_n; // [R5]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            byte_count_o <= '0;
        end
        else if (init_rise && !lines.select_in_n)
        begin
            byte_count_o <= '0; // [R5]
        end
        else if (state == ST_HANDOFF && mode && byte_ready_i)
        begin
            byte_count_o <= byte_count_o + COUNT_W'(1); // [R4]
        end
    end

    // ----------------------------------------
    // Mode-driven select, static fault and paper-out lines
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            select_o    <= SELECT_RESET;
            fault_n_o   <= FAULT_N_RESET;
            paper_out_o <= PAPER_OUT_RESET;
        end
        else
        begin
            select_o    <= mode;           // [R6] [R7]
            fault_n_o   <= FAULT_N_RESET;
            paper_out_o <= PAPER_OUT_RESET;
        end
    end

endmodule // parallel_download_receiver

/* testbench/pdr_monitor.sv */
/* Port checker for the download receiver.
   Assumes one clock domain; bound to the top module. */
`timescale 1ns/1ns
module pdr_monitor
    import pdr_pkg::*;
(
    input wire logic               clk_i,
    input wire logic               reset_n_i,
    input wire logic               byte_ready_i,
    input wire logic               ack_n_o,
    input wire logic               busy_o,
    input wire logic               paper_out_o,
    input wire logic               select_o,
    input wire logic               fault_n_o,
    input wire logic [DATA_W-1:0]  byte_o,
    input wire logic               byte_valid_o,
    input wire logic               download_mode_o,
    input wire logic               download_start_o,
    input wire logic [COUNT_W-1:0] byte_count_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_ack_width;
        $fell(ack_n_o) |-> ##1 (!ack_n_o)[*8] ##1 !ack_n_o ##1 ack_n_o;
    endproperty
    a_ack_width: assert property (p_ack_width) else $error("ack width wrong");
    property p_busy_ack;
        !ack_n_o |-> busy_o;
    endproperty
    a_busy_ack: assert property (p_busy_ack) else $error("busy low in ack");
    property p_valid_busy;
        byte_valid_o |-> busy_o;
    endproperty
    a_valid_busy: assert property (p_valid_busy) else $error("busy low with byte");
    property p_take;
        byte_valid_o && byte_ready_i && download_mode_o |=> !byte_valid_o && !ack_n_o;
    endproperty
    a_take: assert property (p_take) else $error("handoff not answered");
    property p_count;
        byte_valid_o && byte_ready_i && download_mode_o |=> byte_count_o == $past(byte_count_o) + 1;
    endproperty
    a_count: assert property (p_count) else $error("count not stepped");
    property p_hold;
        byte_valid_o && !byte_ready_i |=> $stable(byte_o);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while waiting");
    property p_mode_busy;
        !download_mode_o |-> busy_o && select_o == download_mode_o;
    endproperty
    a_mode_busy: assert property (p_mode_busy) else $error("busy low outside mode");
    property p_start;
        download_start_o |=> !download_start_o && byte_count_o == 0;
    endproperty
    a_start: assert property (p_start) else $error("start pulse wrong");
    property p_fixed;
        !paper_out_o && fault_n_o;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed status moved");
    c_take: cover property (byte_valid_o && byte_ready_i);
    c_stall: cover property (byte_valid_o && !byte_ready_i);
    c_start: cover property (download_start_o);
endmodule // pdr_monitor
bind parallel_download_receiver pdr_monitor i_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .byte_ready_i(byte_ready_i), .ack_n_o(ack_n_o), .busy_o(busy_o), .paper_out_o(paper_out_o),
    .select_o(select_o), .fault_n_o(fault_n_o), .byte_o(byte_o), .byte_valid_o(byte_valid_o),
    .download_mode_o(download_mode_o), .download_start_o(download_start_o), .byte_count_o(byte_count_o));

/* testbench/host_model.sv */
/* Compatibility-mode host port model.
   Assumes status lines from the receiver on the same clock. */
`timescale 1ns/1ns
module host_model
    import pdr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_n_i,
    input  wire logic        busy_i,
    output logic [DATA_W-1:0] data_o,
    output logic             strobe_n_o,
    output logic             autofd_n_o,
    output logic             init_n_o,
    output logic             select_in_n_o
);
    initial
    begin
        data_o = 8'h00;
        strobe_n_o = 1'b1;
        autofd_n_o = 1'b1;
        init_n_o = 1'b0;
        select_in_n_o = 1'b0;
    end
    // One handshake per byte
    task send(input logic [DATA_W-1:0] b, output bit ok);
        int n;
        n = 0;
        while (busy_i !== 1'b0 && n < 500)
        begin
            @(posedge clk_i);
            n++;
        end
        data_o <= b;
        repeat (6) @(posedge clk_i);
        strobe_n_o <= 1'b0;
        while (ack_n_i !== 1'b0 && n < 1000)
        begin
            @(posedge clk_i);
            n++;
        end
        strobe_n_o <= 1'b1;
        data_o <= ~b;
        ok = (n < 1000);
    endtask
    task mode(input logic sel_n, input logic init_n);
        @(posedge clk_i);
        select_in_n_o <= sel_n;
        init_n_o <= init_n;
        repeat (12) @(posedge clk_i);
    endtask
    // Strobe with no busy check
    task poke();
        @(posedge clk_i);
        strobe_n_o <= 1'b0;
        repeat (10) @(posedge clk_i);
        strobe_n_o <= 1'b1;
        repeat (10) @(posedge clk_i);
    endtask
endmodule // host_model

/* testbench/testbench.sv */
/* Self-checking bench for the download receiver.
   Assumes the host model drives the port lines. */
`timescale 1ns/1ns
module testbench;
    import pdr_pkg::*;
    typedef struct {logic [7:0] d; logic [31:0] cnt;} row_s;
    logic               clk_i;
    logic               reset_n_i;
    logic               byte_ready_i;
    logic [DATA_W-1:0]  data;
    logic               strobe_n, autofd_n, init_n, select_in_n;
    logic               ack_n_o, busy_o, paper_out_o, select_o, fault_n_o;
    logic [DATA_W-1:0]  byte_o;
    logic               byte_valid_o, download_mode_o, download_start_o;
    logic [COUNT_W-1:0] byte_count_o;
    int                 n_fail, total_checks, n;
    bit                 ok;
    time                t0;
    row_s rows [4] = '{'{8'hFF, 32'h1}, '{8'h00, 32'h2}, '{8'hA5, 32'h3}, '{8'h5A, 32'h4}};

    host_model host (.clk_i(clk_i), .ack_n_i(ack_n_o), .busy_i(busy_o), .data_o(data),
        .strobe_n_o(strobe_n), .autofd_n_o(autofd_n), .init_n_o(init_n), .select_in_n_o(select_in_n));
    parallel_download_receiver i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .data_i(data),
        .strobe_n_i(strobe_n), .autofd_n_i(autofd_n), .init_n_i(init_n), .select_in_n_i(select_in_n),
        .ack_n_o(ack_n_o), .busy_o(busy_o), .paper_out_o(paper_out_o), .select_o(select_o),
        .fault_n_o(fault_n_o), .byte_o(byte_o), .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
        .download_mode_o(download_mode_o), .download_start_o(download_start_o), .byte_count_o(byte_count_o));

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wait_start();
        n = 0;
        while (download_start_o !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        check("start", 32'h1, download_start_o);
        @(posedge clk_i);
        #1 check("count clear", 32'h0, byte_count_o);
    endtask
    task end_sim();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial
    begin
        #3000000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        reset_n_i <= 1'b0;
        byte_ready_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1 check("reset", 32'h18, {ack_n_o, busy_o, byte_valid_o, download_mode_o, byte_count_o[0]});
        host.mode(1'b0, 1'b0);
        fork
            host.mode(1'b0, 1'b1);
            wait_start();
        join
        #1 check("mode", 32'h3, {download_mode_o, select_o});
        t0 = $time;
        foreach (rows[i])
        begin
            host.send(rows[i].d, ok);
            #1 check("acked", 32'h1, ok);
            check("byte", rows[i].d, byte_o);
            check("count", rows[i].cnt, byte_count_o);
        end
        check("rate", 32'h1, ($time - t0) <= 4 * BYTE_PERIOD_NS);
        @(posedge clk_i);
        byte_ready_i <= 1'b0;
        fork
            host.send(8'h3C, ok);
            begin
                repeat (40) @(posedge clk_i);
                #1 check("stall", 32'h73C, {ack_n_o, busy_o, byte_valid_o, byte_o});
                @(posedge clk_i) byte_ready_i <= 1'b1;
            end
        join
        #1 check("stall count", 32'h5, byte_count_o);
        repeat (20) @(posedge clk_i);
        host.mode(1'b1, 1'b1);
        #1 check("abort", 32'h4, {busy_o, download_mode_o, select_o});
        host.poke();
        #1 check("ignored", 32'h5, byte_count_o);
        host.mode(1'b0, 1'b0);
        fork
            host.mode(1'b0, 1'b1);
            wait_start();
        join
        host.send(8'hC3, ok);
        #1 check("restart", 32'h1C3, {byte_count_o[0], byte_o});
        end_sim();
    end
endmodule // testbench
